// ---- hdl/dcie_pkg.sv ----
// Constants shared by the dual channel input evaluator.
// Assumes a single 10 MHz clock and APB register access.
`default_nettype none
package dcie_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DT1  = 8'h04;
   localparam logic [7:0] REG_DT2  = 8'h08;
   localparam logic [7:0] REG_FILT = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_ACK  = 8'h14;

   // Control field positions
   localparam int CTRL_MODE  = 0;   // 0 standard, 1 rotary table
   localparam int CTRL_TWO   = 1;   // two-channel enable, pairs at 1..2
   localparam int CTRL_ANTI  = 3;   // 1 antivalent, pairs at 3..4
   localparam int CTRL_RINH  = 5;   // restart inhibit, pairs at 5..6
   localparam int CTRL_SCT   = 8;   // short-circuit test, inputs at 8..11
   localparam int CTRL_W     = 12;

   // Status field positions
   localparam int STAT_PI    = 0;   // process image, 4 bits
   localparam int STAT_PASS  = 4;
   localparam int STAT_ERR   = 5;   // two bits
   localparam int STAT_RUN   = 7;   // two bits
   localparam int STAT_SCT   = 9;   // four bits
   localparam int ACK_BIT    = 0;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h060;
   localparam logic [15:0]       DT_RST   = 16'h0064;  // 100 ms
   localparam logic [15:0]       DT_MIN   = 16'h000a;  // 10 ms
   localparam logic [7:0]        FILT_RST = 8'h03;     // 3 ms

   // Timing: one millisecond tick from the system clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

endpackage
`default_nettype wire

// ---- hdl/dcie_filter.sv ----
// One input channel: pin synchroniser and millisecond filter.
// Assumes tick is a one-cycle pulse per millisecond on clock.
`timescale 1ns/1ns
`default_nettype none
module dcie_filter
   import dcie_pkg::*;
(
   input  wire logic       clock,     // System clock
   input  wire logic       reset_n,   // Synchronous reset
   input  wire logic       tick,      // Millisecond enable
   input  wire logic [7:0] filt_ms,   // Filter time, 0 bypasses
   input  wire logic       pin,       // Raw field input
   output logic            level      // Filtered level
);
   logic       sync1;
   logic       sync2;
   logic       sync3;
   logic       cand;
   logic [7:0] cnt;

   // Three-stage synchroniser; only stages two and three are compared
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         cand  <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3) begin
            cand <= sync3;
         end
      end
   end

   // Level accepted only after persisting the filter time
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         level <= 1'b0;
         cnt   <= 8'h00;
      end else if (cand == level) begin
         cnt <= 8'h00;
      end else if (filt_ms == 8'h00) begin
         level <= cand;                   // RL17
      end else if (tick) begin
         if (cnt + 8'h01 >= filt_ms) begin
            level <= cand;                // RL17
            cnt   <= 8'h00;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/dcie_top.sv ----
// Dual channel input evaluator: four filtered safety inputs,
// two pairs, valence rules, discrepancy timers and passivation.
// Assumes an APB master on clock and a same-clock acknowledge.
//
// Behaviour
// RL1: Two-channel pair with mismatched short-circuit settings forces both active.
// RL2: Discrepancy timing only in standard mode with two-channel enabled.
// RL3: Per-pair discrepancy time, 10 to 65535 ms, one ms steps.
// RL4: Timer starts at once when the pair first violates its rule.
// RL5: Illegal state beyond the time gives error, passivation, timeout report.
// RL6: Timing works on filtered levels only.
// RL7: Started from one, timer stops only at the valid zero state.
// RL8: Started from zero, timer stops at either valid state.
// RL9: Running timer reports zero for that pair.
// RL10: Any discrepancy error drives all process bits to zero.
// RL11: One acknowledge clears all affected pairs, each per restart inhibit.
// RL12: Per-pair valence select, used only in standard two-channel mode.
// RL13: Antivalent: upper low, lower high sets lower bit; else zero.
// RL14: Equivalent: both high set both bits; mismatches report zero.
// RL15: Inputs one and two form pair one, three and four pair two.
// RL16: Without two-channel, each input reports in its own bit.
// RL17: Levels accepted after the filter time; zero bypasses filter.
// RL18: Without restart inhibit, acknowledge succeeds once rule is met.
// RL19: Millisecond tick; sixteen-bit down counter loaded at timer start.
// RL20: Passivation holds until valid acknowledge; reset clears it all.
`timescale 1ns/1ns
`default_nettype none
module dcie_top
   import dcie_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES  // Clock cycles per millisecond
)
(
   input  wire logic        clock,              // System clock
   input  wire logic        reset_n,            // Synchronous reset
   input  wire logic        psel,               // APB select
   input  wire logic        penable,            // APB enable
   input  wire logic        pwrite,             // APB direction
   input  wire logic [7:0]  paddr,              // APB byte address
   input  wire logic [31:0] pwdata,             // APB write data
   output logic [31:0]      prdata,             // APB read data
   output logic             pready,             // APB ready
   output logic             pslverr,            // APB error
   input  wire logic        pair1_lower_input,  // Field input one
   input  wire logic        pair1_upper_input,  // Field input two
   input  wire logic        pair2_lower_input,  // Field input three
   input  wire logic        pair2_upper_input,  // Field input four
   input  wire logic        ack,                // Controller acknowledge pulse
   output logic [3:0]       process_image,      // Safe process bits
   output logic [1:0]       diag_timeout,       // Discrepancy timeout per pair
   output logic             passivated,         // Module passivated
   output logic [3:0]       sc_test_active      // Effective short-circuit test
);
   logic [CTRL_W-1:0] ctrl;
   logic [15:0]       dtime [2];
   logic [7:0]        filt_ms;
   logic [15:0]       next_dtime;
   logic              ack_wr;
   logic              ack_any;
   logic [15:0]       tick_cnt;
   logic              tick;
   logic [3:0]        pins;
   logic [3:0]        filt;
   logic [1:0]        running;
   logic [1:0]        err;
   logic [1:0]        err_set;
   logic [1:0]        err_clr;
   logic [1:0]        eval_en;
   logic [1:0]        valid0;
   logic [1:0]        valid1;
   logic [1:0]        illegal;
   logic [1:0]        rep;
   logic [1:0]        start_val;
   logic [15:0]       cnt [2];
   logic [3:0]        next_image;
   logic [3:0]        next_sct;
   logic [31:0]       next_rdata;
   logic              next_err;
   logic              access_wr;

   // Millisecond enable from the system clock
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else if (tick_cnt >= 16'(TICK_LEN - 1)) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b1;                     // RL19
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick     <= 1'b0;
      end
   end

   // Input order: lower inputs at even bits, upper at odd
   assign pins = {pair2_upper_input, pair2_lower_input,
                  pair1_upper_input, pair1_lower_input};  // RL15

   // One filter per input channel
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_in
         dcie_filter u_filt (
            .clock   (clock),
            .reset_n (reset_n),
            .tick    (tick),
            .filt_ms (filt_ms),
            .pin     (pins[gi]),
            .level   (filt[gi])
         );
      end
   endgenerate

   // APB: always ready; write at the access edge
   assign pready    = 1'b1;
   assign access_wr = psel && penable && pwrite;
   assign ack_wr    = access_wr && (paddr == REG_ACK) && pwdata[ACK_BIT];
   assign ack_any   = ack || ack_wr;

   // Short writes clamp to the least legal time
   assign next_dtime = (pwdata[15:0] < DT_MIN) ? DT_MIN : pwdata[15:0];  // RL3

   // Configuration registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ctrl     <= CTRL_RST;
         dtime[0] <= DT_RST;
         dtime[1] <= DT_RST;
         filt_ms  <= FILT_RST;
      end else if (access_wr) begin
         case (paddr)
            REG_CTRL: ctrl     <= pwdata[CTRL_W-1:0];
            REG_DT1:  dtime[0] <= next_dtime;    // RL3
            REG_DT2:  dtime[1] <= next_dtime;    // RL3
            REG_FILT: filt_ms  <= pwdata[7:0];
            default:  ;
         endcase
      end
   end

   // Read data and error captured in the setup cycle
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (paddr)
         REG_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
         REG_DT1:  next_rdata[15:0]       = dtime[0];
         REG_DT2:  next_rdata[15:0]       = dtime[1];
         REG_FILT: next_rdata[7:0]        = filt_ms;
         REG_STAT: begin
            next_rdata[STAT_PI +: 4]  = process_image;
            next_rdata[STAT_PASS]     = passivated;
            next_rdata[STAT_ERR +: 2] = err;
            next_rdata[STAT_RUN +: 2] = running;
            next_rdata[STAT_SCT +: 4] = sc_test_active;
         end
         REG_ACK:  ;
         default:  next_err = 1'b1;
      endcase
   end

   // Answer held from setup so it stands through the access phase
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= next_err;
      end
   end

   // Per-pair valence decode and timer
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_pair
         logic lo;
         logic up;
         logic anti;
         logic stop;
         logic ack_ok;
         assign lo   = filt[2*gp];                 // RL6
         assign up   = filt[2*gp+1];               // RL6
         assign anti = ctrl[CTRL_ANTI+gp];         // RL12
         // Evaluation only in standard mode with two channels
         assign eval_en[gp] = !ctrl[CTRL_MODE] && ctrl[CTRL_TWO+gp];  // RL2
         assign valid1[gp]  = anti ? (!up && lo) : (up && lo);        // RL13
         assign valid0[gp]  = anti ? (up && !lo) : (!up && !lo);      // RL14
         assign illegal[gp] = !valid0[gp] && !valid1[gp];
         // Stop depends on the value reported when timing began
         assign stop = start_val[gp] ? valid0[gp]                     // RL7
                                     : (valid0[gp] || valid1[gp]);    // RL8
         // Inhibit demands the safe zero state, else any legal state
         assign ack_ok = ctrl[CTRL_RINH+gp] ? valid0[gp]
                                            : !illegal[gp];           // RL18
         assign err_clr[gp] = ack_any && ack_ok;                      // RL11
         assign err_set[gp] = running[gp] && !stop && tick
                              && (cnt[gp] == 16'h0000);               // RL5

         // Timer state, cleared by reset and when evaluation is off
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               running[gp]   <= 1'b0;
               start_val[gp] <= 1'b0;
               rep[gp]       <= 1'b0;
               cnt[gp]       <= 16'h0000;
            end else if (!eval_en[gp] || err[gp]) begin
               running[gp] <= 1'b0;                                   // RL2
               rep[gp]     <= 1'b0;
            end else if (!running[gp]) begin
               if (illegal[gp]) begin
                  running[gp]   <= 1'b1;                              // RL4
                  start_val[gp] <= rep[gp];
                  cnt[gp]       <= dtime[gp];                         // RL19
               end else begin
                  rep[gp] <= valid1[gp];
               end
            end else if (stop) begin
               running[gp] <= 1'b0;
               rep[gp]     <= valid1[gp];
            end else if (err_set[gp]) begin
               running[gp] <= 1'b0;                                   // RL5
            end else if (tick) begin
               cnt[gp] <= cnt[gp] - 16'h0001;                         // RL19
            end
         end

         // Sticky error; a new timeout wins over an acknowledge
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               err[gp] <= 1'b0;                                       // RL20
            end else if (err_set[gp]) begin
               err[gp] <= 1'b1;                                       // RL5
            end else if (err_clr[gp]) begin
               err[gp] <= 1'b0;                                       // RL20
            end
         end

         // Pair contribution to the process image
         always_comb begin
            if (!eval_en[gp]) begin
               next_image[2*gp+1 -: 2] = {up, lo};                    // RL16
            end else if (running[gp]) begin
               next_image[2*gp+1 -: 2] = 2'b00;                       // RL9
            end else if (anti) begin
               next_image[2*gp+1 -: 2] = {1'b0, valid1[gp]};          // RL13
            end else begin
               next_image[2*gp+1 -: 2] = {valid1[gp], valid1[gp]};    // RL14
            end
         end

         // Mismatched short-circuit settings on a two-channel pair force the test on
         always_comb begin
            if (ctrl[CTRL_TWO+gp]
                && (ctrl[CTRL_SCT+2*gp] != ctrl[CTRL_SCT+2*gp+1])) begin
               next_sct[2*gp+1 -: 2] = 2'b11;                         // RL1
            end else begin
               next_sct[2*gp+1 -: 2] = ctrl[CTRL_SCT+2*gp +: 2];
            end
         end
      end
   endgenerate

   // Registered outputs; any error zeroes every input bit
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         process_image  <= 4'h0;
         diag_timeout   <= 2'b00;
         passivated     <= 1'b0;
         sc_test_active <= 4'h0;
      end else begin
         passivated     <= |err;                                      // RL10
         diag_timeout   <= err;                                       // RL5
         sc_test_active <= next_sct;                                  // RL1
         process_image  <= (|err) ? 4'h0 : next_image;                // RL10
      end
   end
endmodule
`default_nettype wire

// ---- verification/dcie_props.sv ----
// Port checker for dcie_top, bound after the module.
// Assumes CTRL changes only through completed APB writes.
`timescale 1ns/1ns
`default_nettype none
module dcie_props
   import dcie_pkg::*;
(
   input wire logic        clock,          // Clock
   input wire logic        reset_n,        // Reset
   input wire logic        psel,           // Select
   input wire logic        penable,        // Enable
   input wire logic        pwrite,         // Write
   input wire logic [7:0]  paddr,          // Address
   input wire logic [31:0] pwdata,         // Write data
   input wire logic [31:0] prdata,         // Read data
   input wire logic        pready,         // Ready
   input wire logic        pslverr,        // Error
   input wire logic        ack,            // Acknowledge
   input wire logic [3:0]  process_image,  // Image
   input wire logic [1:0]  diag_timeout,   // Errors
   input wire logic        passivated,     // Passive
   input wire logic [3:0]  sc_test_active  // Test
);
   logic [11:0] ctrl;  // Shadow control word
   logic        wr;    // Completing write
   logic        ackd;  // Any acknowledge
   logic [3:0]  sct;   // Expected test setting
   // Shadowing avoids probing design internals
   assign wr = psel & penable & pwrite & pready;
   assign ackd = ack | (wr & (paddr == REG_ACK) & pwdata[0]);
   assign sct = {ctrl[2] ? {2{|ctrl[11:10]}} : ctrl[11:10],
                 ctrl[1] ? {2{|ctrl[9:8]}} : ctrl[9:8]};
   // Follow control writes
   always_ff @(posedge clock) begin
      if (!reset_n)
         ctrl <= CTRL_RST;
      else if (wr && paddr == REG_CTRL)
         ctrl <= pwdata[11:0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_pready_high: assert property (pready) else $error("pready low");
   a_sct_forced: assert property ($stable(ctrl) |-> sc_test_active == sct)
      else $error("test setting wrong");
   a_passive_blank: assert property (passivated |-> process_image == 4'h0)
      else $error("image not blanked");
   a_passive_or: assert property (passivated == |diag_timeout)
      else $error("passivation differs from errors");
   a_err_held: assert property (|($past(diag_timeout) & ~diag_timeout) |->
      $past(ackd) || $past(ackd, 2) || $past(ackd, 3)) else $error("error cleared alone");
   a_zero_first1: assert property ($rose(diag_timeout[0]) |->
      ($past(process_image) & 4'h3) == 4'h0) else $error("pair one not zero");
   a_zero_first2: assert property ($rose(diag_timeout[1]) |->
      ($past(process_image) & 4'hc) == 4'h0) else $error("pair two not zero");
   a_unmapped_err: assert property (psel && !penable && paddr > REG_ACK |=>
      pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_mapped_ok: assert property (psel && !penable && paddr <= REG_ACK &&
      paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped refused");
endmodule
bind dcie_top dcie_props chk_u (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .ack, .process_image, .diag_timeout, .passivated, .sc_test_active);
`default_nettype wire

// ---- verification/dcie_ctrl_model.sv ----
// Safety controller model: sends the acknowledge pulse.
// Assumes the bench asks for each acknowledge with a one-cycle request.
`timescale 1ns/1ns
`default_nettype none
module dcie_ctrl_model
(
   input  wire logic       clock,    // System clock
   input  wire logic       reset_n,  // Synchronous reset
   input  wire logic       ack_req,  // Bench request
   input  wire logic [3:0] ack_dly,  // Answer delay in cycles
   output logic            ack       // One-cycle acknowledge
);
   logic [4:0] cnt;  // Cycles left, zero when idle
   // Delay lets the bench answer promptly or slowly
   always_ff @(posedge clock) begin
      if (!reset_n)
         cnt <= 5'h00;
      else if (ack_req)
         cnt <= {1'b0, ack_dly} + 5'h01;
      else if (cnt != 5'h00)
         cnt <= cnt - 5'h01;
   end
   // One pulse clears at once every errored pair that meets its acknowledge rule
   always_ff @(posedge clock) begin
      if (!reset_n)
         ack <= 1'b0;
      else
         ack <= (cnt == 5'h01) && !ack_req;
   end
endmodule
`default_nettype wire

// ---- verification/dual_channel_input_evaluator_tb.sv ----
// Bench for dcie_top: table of evaluation cases, then error handling.
// Assumes ten-cycle milliseconds and the controller model beside it.
`timescale 1ns/1ns
`default_nettype none
module dual_channel_input_evaluator_tb;
   import dcie_pkg::*;
   typedef struct packed {
      logic [11:0] ctrl;
      logic [3:0]  pins;
      logic [3:0]  img;
      logic [3:0]  sct;
   } dcie_row_s;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pins = 4'h0;  // Bit 0 is input one
   logic        ack_req = 1'b0;
   logic [3:0]  ack_dly = 4'h0;
   logic        ack;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        passivated;
   logic [1:0]  diag_timeout;
   logic [3:0]  process_image;
   logic [3:0]  sc_test_active;
   logic [31:0] rd;
   logic        er;
   int          n_fail = 0;
   int          checks = 0;
   int          cyc = 0;
   localparam logic [7:0]  RA [5] = '{REG_CTRL, REG_DT1, REG_DT2, REG_FILT, REG_STAT};
   localparam logic [31:0] RV [5] = '{32'(CTRL_RST), 32'(DT_RST), 32'(DT_RST),
                                      32'(FILT_RST), 32'h0};
   // Control, pins, expected image, expected test setting
   dcie_row_s   rows [12] = '{
      '{12'h060, 4'ha, 4'ha, 4'h0}, '{12'h060, 4'h5, 4'h5, 4'h0},
      '{12'h066, 4'hf, 4'hf, 4'h0}, '{12'h066, 4'h0, 4'h0, 4'h0},
      '{12'h07e, 4'h5, 4'h5, 4'h0}, '{12'h07e, 4'ha, 4'h0, 4'h0},
      '{12'h07e, 4'hf, 4'h0, 4'h0}, '{12'h07e, 4'h5, 4'h5, 4'h0},
      '{12'h067, 4'h9, 4'h9, 4'h0}, '{12'h166, 4'h0, 4'h0, 4'h3},
      '{12'h960, 4'h0, 4'h0, 4'h9}, '{12'h864, 4'h0, 4'h0, 4'hc}};
   always #50 clock = ~clock;
   dcie_top #(.TICK_LEN(10)) dut_u (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pair1_lower_input(pins[0]),
      .pair1_upper_input(pins[1]), .pair2_lower_input(pins[2]),
      .pair2_upper_input(pins[3]), .ack, .process_image, .diag_timeout, .passivated,
      .sc_test_active);
   dcie_ctrl_model ctl_u (.clock, .reset_n, .ack_req, .ack_dly, .ack);
   task automatic stop_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
   endtask
   // One transfer, held until pready, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic set_pins(input logic [3:0] p, input int n);
      pins <= p;
      tk(n);
   endtask
   task automatic do_ack(input logic [3:0] d);
      ack_dly <= d;
      ack_req <= 1'b1;
      @(posedge clock);
      ack_req <= 1'b0;
      tk(int'(d) + 8);
   endtask
   // Watchdog against a hung handshake
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         $display("BAD %0t watchdog expired", $time);
         stop_test();
      end
   end
   initial begin
      tk(12);
      chk({25'h0, process_image, passivated, diag_timeout}, 32'h0, "reset out");
      reset_n <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, RA[i], 32'h0);
         chk(rd, RV[i], "reset value");
      end
      apb(1'b1, REG_FILT, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, REG_CTRL, 32'(rows[i].ctrl));
         set_pins(rows[i].pins, 8);
         chk(32'(process_image), 32'(rows[i].img), "image");
         chk(32'(sc_test_active), 32'(rows[i].sct), "test setting");
      end
      apb(1'b1, REG_DT1, 32'h5);
      apb(1'b0, REG_DT1, 32'h0);
      chk(rd, 32'(DT_MIN), "time floor");
      apb(1'b1, REG_DT2, 32'hffff);
      apb(1'b0, REG_DT2, 32'h0);
      chk(rd, 32'hffff, "time ceiling");
      apb(1'b1, REG_DT2, 32'ha);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped read");
      // Pair one leaves one and returns to one: timer must keep running
      apb(1'b1, REG_CTRL, 32'h066);
      set_pins(4'hf, 8);
      set_pins(4'hd, 8);
      chk(32'(process_image), 32'hc, "running pair");
      apb(1'b0, REG_STAT, 32'h0);
      chk(rd, (32'hc << STAT_PI) | (32'h1 << STAT_RUN), "status running");
      set_pins(4'hf, 40);
      chk(32'(diag_timeout), 32'h0, "early timeout");
      chk(32'(process_image), 32'hc, "still running");
      tk(90);
      chk({29'h0, passivated, diag_timeout}, 32'h5, "timeout");
      chk(32'(process_image), 32'h0, "passive image");
      apb(1'b0, REG_STAT, 32'h0);
      chk(rd, (32'h1 << STAT_PASS) | (32'h1 << STAT_ERR), "status passive");
      do_ack(4'h0);
      chk(32'(diag_timeout), 32'h1, "ack refused");
      set_pins(4'h0, 8);
      do_ack(4'h9);
      chk({29'h0, passivated, diag_timeout}, 32'h0, "ack taken");
      // Both pairs fail together and share one acknowledge
      set_pins(4'h5, 140);
      chk(32'(diag_timeout), 32'h3, "both timeouts");
      set_pins(4'h0, 8);
      do_ack(4'h0);
      chk(32'(diag_timeout), 32'h0, "both cleared");
      // Without restart inhibit a legal one state is enough
      apb(1'b1, REG_CTRL, 32'h006);
      set_pins(4'hf, 8);
      set_pins(4'hd, 140);
      set_pins(4'hf, 8);
      chk(32'(diag_timeout), 32'h1, "error held");
      apb(1'b1, REG_ACK, 32'h1);
      tk(6);
      chk({28'h0, process_image}, 32'hf, "ack no inhibit");
      // Filter holds a fresh change back for its full time
      apb(1'b1, REG_FILT, 32'h2);
      apb(1'b1, REG_CTRL, 32'h060);
      set_pins(4'he, 12);
      chk(32'(process_image), 32'hf, "filter hold");
      tk(30);
      chk(32'(process_image), 32'he, "filter pass");
      reset_n <= 1'b0;
      tk(3);
      reset_n <= 1'b1;
      apb(1'b0, REG_FILT, 32'h0);
      chk(rd, 32'(FILT_RST), "second reset");
      stop_test();
   end
endmodule
`default_nettype wire
